// [logic/pmrc_regs.svh]
// Constants of the power mode and reset control block
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH
`define PMRC_DIV_RSVD        2'h0
`define PMRC_DIV_4           2'h1
`define PMRC_DIV_64          2'h2
`define PMRC_DIV_1024        2'h3
`define PMRC_MC_LEN_4        11'h004
`define PMRC_MC_LEN_64       11'h040
`define PMRC_MC_LEN_1024     11'h400
`define PMRC_WD_RESET_CLOCKS 512
`define PMRC_RST_HOLD_MC     2'h2
`define PMRC_SRC_RC          1'h0
`define PMRC_SRC_CRYSTAL     1'h1
`define PMRC_SRC_RESET       1'h1
`endif

// [logic/pmrc_pkg.sv]
// Types and helper functions of the power mode and reset control block
`include "pmrc_regs.svh"
package pmrc_pkg;
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_IDLE  = 2'b01,
    MODE_PDOWN = 2'b10,
    MODE_RESET = 2'b11
  } pmrc_mode_e;

  typedef struct packed {
    logic       idleWr;
    logic       pdWr;
    logic       divWr;
    logic [1:0] divSel;
    logic       clkSrcWr;
    logic       clkSrcSel;
    logic       swbEn;
    logic       crystalAmpOff;
    logic       rcWakeSelect;
    logic [1:0] extLevelMode;
    logic [1:0] extIrqEnable;
    logic       globalIrqEnable;
  } pmrc_ctrl_s;

  typedef struct packed {
    logic rxEnable;
    logic txBufWrite;
    logic extIrqAck;
    logic serialBusy;
  } pmrc_event_s;

  typedef struct packed {
    logic       idleBit;
    logic       pdBit;
    logic [1:0] divCode;
    logic       clkSrcStatus;
    logic       crystalReady;
    logic       coreCycleEn;
    logic       periphCycleEn;
    logic       cpuReset;
    logic       wdReset;
    logic       portFreeze;
    logic       addrLatchStrobe;
    logic       progFetchStrobe;
    logic       oscRun;
    logic       rcOscOn;
    logic       crystalAmpOn;
  } pmrc_status_s;

  typedef struct packed {
    logic [1:0]      rstPinSync;
    logic [1:0]      pfSync;
    logic [1:0]      xtalSync;
    logic [2:0]      rxSync;
    logic [1:0][1:0] extSync;
    pmrc_mode_e      mode;
    logic            idleBit;
    logic            pdBit;
    logic [1:0]      div;
    logic            divPend;
    logic            divStage;
    logic [1:0]      divNew;
    logic            clkSrc;
    logic            srcPend;
    logic            srcStage;
    logic            srcNew;
    logic            autoBack;
    logic            rstSampled;
    logic [1:0]      holdCnt;
    logic            wdArmed;
    logic [9:0]      wdCount;
    pmrc_status_s    out;
  } pmrc_state_s;

  typedef struct packed {
    logic [10:0] cnt;
    logic        cycleEnd;
    logic        fourth;
  } pmrc_div_state_s;

  function automatic logic [10:0] pmrc_mc_length(input logic [1:0] code);
    case (code)
      `PMRC_DIV_64:   return `PMRC_MC_LEN_64;
      `PMRC_DIV_1024: return `PMRC_MC_LEN_1024;
      default:        return `PMRC_MC_LEN_4;
    endcase
  endfunction : pmrc_mc_length

  // One machine cycle of delay: arm on the first cycle end, apply on the second
  function automatic logic [2:0] pmrc_delay_step(input logic pend, input logic stage,
                                                 input logic tick);
    if (!pend || !tick) return {1'b0, pend, stage};
    if (stage) return 3'b100;
    return 3'b011;
  endfunction : pmrc_delay_step

  function automatic pmrc_state_s pmrc_reset_state();
    pmrc_state_s r;
    r = '0;
    r.mode = MODE_RESET;
    r.div = `PMRC_DIV_4;
    r.clkSrc = `PMRC_SRC_RESET;
    r.holdCnt = `PMRC_RST_HOLD_MC;
    r.out.divCode = `PMRC_DIV_4;
    r.out.clkSrcStatus = `PMRC_SRC_RESET;
    r.out.cpuReset = 1'b1;
    r.out.oscRun = 1'b1;
    r.out.crystalAmpOn = 1'b1;
    return r;
  endfunction : pmrc_reset_state
endpackage : pmrc_pkg

// [logic/pmrc_cycle_div.sv]
// Machine-cycle divider giving a cycle-end pulse and a fourth-state pulse
`timescale 1ns/100ps
`default_nettype none
module pmrc_cycle_div (
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       run,
  input  wire logic [1:0] divCode,
  output logic            cycleEnd,
  output logic            fourthState
);
  pmrc_pkg::pmrc_div_state_s s;
  pmrc_pkg::pmrc_div_state_s next_s;
  logic [10:0]               len;

  always_comb begin
    len = pmrc_pkg::pmrc_mc_length(divCode);
    next_s = s;
    next_s.cycleEnd = 1'b0;
    next_s.fourth = 1'b0;
    if (run) begin
      // A shorter new length is caught by the compare, so no cycle stalls
      if (s.cnt >= len - 11'h001) begin
        next_s.cnt = '0;
        next_s.cycleEnd = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 11'h001;
      end
      next_s.fourth = (s.cnt == len - (len >> 2));
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cycleEnd = s.cycleEnd;
  assign fourthState = s.fourth;
endmodule : pmrc_cycle_div
`default_nettype wire

// [logic/pmrc_power_ctrl.sv]
// Power mode, economy divider, clock source and reset sequencing top
//
// Behaviour
// - Idle bit set enters idle when the setting instruction completes.
// - Idle halts the CPU cycle enable; peripherals keep their enable.
// - In idle both bus strobes read high and ports are frozen.
// - Enabled interrupt in idle clears the idle bit and resumes running.
// - Reset during idle goes straight to the reset sequence.
// - Watchdog reset issues 512 clocks after time-out unless restarted.
// - Divide field 01 gives 4, 10 gives 64, 11 gives 1024 clocks.
// - Economy slows peripherals with the core; idle keeps them at divide-by-4.
// - New divide selection takes effect one machine cycle after the write.
// - Source select picks crystal or RC; status shows it after one cycle.
// - Crystal ready flag gates crystal selection; software re-enables amplifier first.
// - Switchback events force divide-by-4 immediately.
// - Receive start edge with receive enabled or transmit buffer write triggers.
// - Divide writes ignored during serial activity with switchback enabled.
// - Every reset source forces divide-by-4.
// - Power-down stops clocks after the instruction; strobes low.
// - Reset pin high ends power-down and restarts from reset.
// - Enabled level-mode external pin low wakes power-down to running.
// - RC wake runs on RC then switches to crystal once ready.
// - Reset pin sampled at the fourth state of each machine cycle.
// - Reset held while pin high and two machine cycles after release.
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.svh"
module pmrc_power_ctrl (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire pmrc_pkg::pmrc_ctrl_s ctrl,
  input  wire pmrc_pkg::pmrc_event_s ev,
  input  wire logic                 instrDone,
  input  wire logic                 irqWake,
  input  wire logic                 serRxPin,
  input  wire logic [1:0]           extIrqPin,
  input  wire logic                 rstPin,
  input  wire logic                 powerFailPin,
  input  wire logic                 crystalWarmPin,
  input  wire logic                 wdTimeout,
  input  wire logic                 wdResetEnable,
  input  wire logic                 wdRestart,
  input  wire logic                 aleIn,
  input  wire logic                 fetchIn,
  output pmrc_pkg::pmrc_status_s    status
);
  localparam pmrc_pkg::pmrc_state_s RST_STATE = pmrc_pkg::pmrc_reset_state();
  localparam int WD_FIRE = `PMRC_WD_RESET_CLOCKS - 1;
  localparam int HOLD_CLOCKS = 4;

  logic [1:0]            rstPipe;
  logic                  rstLocalN;
  pmrc_pkg::pmrc_state_s s;
  pmrc_pkg::pmrc_state_s next_s;
  logic                  coreEnd;
  logic                  coreFourth;
  logic                  fastEnd;
  logic                  oscOn;
  logic                  rxFall;
  logic                  xtalReady;
  logic                  swTrig;
  logic                  pdWake;
  logic                  resetNow;
  logic                  divAccept;
  logic                  srcAccept;
  logic [2:0]            divStep;
  logic [2:0]            srcStep;

  // Reset release is synchronised so every flop leaves reset on one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstLocalN = rstPipe[1];

  assign oscOn = (s.mode != pmrc_pkg::MODE_PDOWN);

  pmrc_cycle_div coreDiv (
    .clk         (clk),
    .rstN        (rstLocalN),
    .run         (oscOn),
    .divCode     (s.div),
    .cycleEnd    (coreEnd),
    .fourthState (coreFourth)
  );

  // Fixed divide-by-4 rate for peripherals while the core idles
  pmrc_cycle_div fastDiv (
    .clk         (clk),
    .rstN        (rstLocalN),
    .run         (oscOn),
    .divCode     (`PMRC_DIV_4),
    .cycleEnd    (fastEnd),
    .fourthState ()
  );

  always_comb begin
    next_s = s;
    next_s.rstPinSync = {s.rstPinSync[0], rstPin};
    next_s.pfSync = {s.pfSync[0], powerFailPin};
    next_s.xtalSync = {s.xtalSync[0], crystalWarmPin};
    next_s.rxSync = {s.rxSync[1:0], serRxPin};
    next_s.extSync[0] = {s.extSync[0][0], extIrqPin[0]};
    next_s.extSync[1] = {s.extSync[1][0], extIrqPin[1]};

    rxFall = s.rxSync[2] & ~s.rxSync[1];
    xtalReady = s.xtalSync[1] & ~ctrl.crystalAmpOff;
    // Serial interrupt flags play no part in the trigger
    swTrig = ctrl.swbEn & ((rxFall & ev.rxEnable) | ev.txBufWrite | ev.extIrqAck);
    pdWake = ctrl.globalIrqEnable & (|(~{s.extSync[1][1], s.extSync[0][1]}
             & ctrl.extLevelMode & ctrl.extIrqEnable));
    divAccept = ctrl.divWr & (ctrl.divSel != `PMRC_DIV_RSVD)
                & ~(ctrl.swbEn & ev.serialBusy);
    srcAccept = ctrl.clkSrcWr & (~ctrl.clkSrcSel | xtalReady);
    divStep = pmrc_pkg::pmrc_delay_step(s.divPend, s.divStage, coreEnd);
    srcStep = pmrc_pkg::pmrc_delay_step(s.srcPend, s.srcStage, coreEnd);

    // With clocks stopped the pin is watched directly, else only at the fourth state
    if (!oscOn) begin
      next_s.rstSampled = s.rstPinSync[1];
    end else if (coreFourth) begin
      next_s.rstSampled = s.rstPinSync[1];
    end

    // Watchdog frozen in power-down, since its clock is stopped there
    next_s.out.wdReset = 1'b0;
    if (oscOn) begin
      if (wdTimeout && wdResetEnable) begin
        next_s.wdArmed = 1'b1;
        next_s.wdCount = '0;
      end else if (wdRestart) begin
        next_s.wdArmed = 1'b0;
      end else if (s.wdArmed) begin
        if (s.wdCount == 10'(WD_FIRE)) begin
          next_s.out.wdReset = 1'b1;
          next_s.wdArmed = 1'b0;
        end else begin
          next_s.wdCount = s.wdCount + 10'h001;
        end
      end
    end

    resetNow = s.rstSampled | s.pfSync[1] | s.out.wdReset;
    if (resetNow) begin
      next_s.mode = pmrc_pkg::MODE_RESET;
      next_s.holdCnt = `PMRC_RST_HOLD_MC;
      next_s.idleBit = 1'b0;
      next_s.pdBit = 1'b0;
      next_s.div = `PMRC_DIV_4;
      next_s.divPend = 1'b0;
      next_s.srcPend = 1'b0;
      next_s.autoBack = 1'b0;
    end else begin
      case (s.mode)
        pmrc_pkg::MODE_RESET: begin
          if (s.holdCnt == 2'h0) begin
            next_s.mode = pmrc_pkg::MODE_RUN;
          end else if (coreEnd) begin
            next_s.holdCnt = s.holdCnt - 2'h1;
          end
        end
        pmrc_pkg::MODE_RUN: begin
          if (ctrl.idleWr) next_s.idleBit = 1'b1;
          if (ctrl.pdWr) next_s.pdBit = 1'b1;
          // Power-down wins when both bits are set by one instruction
          if (instrDone && (s.pdBit || ctrl.pdWr)) begin
            next_s.mode = pmrc_pkg::MODE_PDOWN;
          end else if (instrDone && (s.idleBit || ctrl.idleWr)) begin
            next_s.mode = pmrc_pkg::MODE_IDLE;
          end
        end
        pmrc_pkg::MODE_IDLE: begin
          if (irqWake) begin
            next_s.idleBit = 1'b0;
            next_s.mode = pmrc_pkg::MODE_RUN;
          end
        end
        pmrc_pkg::MODE_PDOWN: begin
          if (pdWake) begin
            next_s.pdBit = 1'b0;
            next_s.mode = pmrc_pkg::MODE_RUN;
            if (ctrl.rcWakeSelect) begin
              next_s.clkSrc = `PMRC_SRC_RC;
              next_s.autoBack = 1'b1;
            end
          end
        end
        default: next_s.mode = pmrc_pkg::MODE_RESET;
      endcase

      // No check between the slow rates; software goes through divide-by-4
      if (swTrig && oscOn) begin
        next_s.div = `PMRC_DIV_4;
        next_s.divPend = 1'b0;
      end else if (divAccept) begin
        next_s.divPend = 1'b1;
        next_s.divStage = 1'b0;
        next_s.divNew = ctrl.divSel;
      end else begin
        {next_s.divPend, next_s.divStage} = divStep[1:0];
        if (divStep[2]) next_s.div = s.divNew;
      end

      if (s.autoBack && xtalReady && oscOn) begin
        next_s.clkSrc = `PMRC_SRC_CRYSTAL;
        next_s.autoBack = 1'b0;
        next_s.srcPend = 1'b0;
      end else if (srcAccept) begin
        next_s.srcPend = 1'b1;
        next_s.srcStage = 1'b0;
        next_s.srcNew = ctrl.clkSrcSel;
      end else begin
        {next_s.srcPend, next_s.srcStage} = srcStep[1:0];
        if (srcStep[2]) next_s.clkSrc = s.srcNew;
      end
    end

    next_s.out.idleBit = next_s.idleBit;
    next_s.out.pdBit = next_s.pdBit;
    next_s.out.divCode = next_s.div;
    next_s.out.clkSrcStatus = next_s.clkSrc;
    next_s.out.crystalReady = xtalReady;
    next_s.out.coreCycleEn = coreEnd && (s.mode == pmrc_pkg::MODE_RUN);
    if (s.mode == pmrc_pkg::MODE_IDLE) begin
      next_s.out.periphCycleEn = fastEnd;
    end else begin
      next_s.out.periphCycleEn = coreEnd && oscOn;
    end
    next_s.out.cpuReset = (next_s.mode == pmrc_pkg::MODE_RESET);
    next_s.out.portFreeze = (next_s.mode == pmrc_pkg::MODE_IDLE);
    case (next_s.mode)
      pmrc_pkg::MODE_IDLE: begin
        next_s.out.addrLatchStrobe = 1'b1;
        next_s.out.progFetchStrobe = 1'b1;
      end
      pmrc_pkg::MODE_PDOWN: begin
        next_s.out.addrLatchStrobe = 1'b0;
        next_s.out.progFetchStrobe = 1'b0;
      end
      default: begin
        next_s.out.addrLatchStrobe = aleIn;
        next_s.out.progFetchStrobe = fetchIn;
      end
    endcase
    next_s.out.oscRun = (next_s.mode != pmrc_pkg::MODE_PDOWN);
    next_s.out.rcOscOn = next_s.out.oscRun && (next_s.clkSrc == `PMRC_SRC_RC);
    // The amplifier of the clock in use, or of one being waited for, stays on
    next_s.out.crystalAmpOn = next_s.out.oscRun && (!ctrl.crystalAmpOff
                              || (next_s.clkSrc == `PMRC_SRC_CRYSTAL) || next_s.autoBack);
  end

  always_ff @(posedge clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign status = s.out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstLocalN);

  sequence seqPdEntry;
    s.mode == pmrc_pkg::MODE_RUN && instrDone && (s.pdBit || ctrl.pdWr) && !resetNow;
  endsequence
  sequence seqIdleEntry;
    s.mode == pmrc_pkg::MODE_RUN && instrDone && (s.idleBit || ctrl.idleWr)
      && !(s.pdBit || ctrl.pdWr) && !resetNow;
  endsequence
  sequence seqWdExpire;
    s.wdArmed && s.wdCount == 10'(WD_FIRE) && !wdRestart && !wdTimeout && oscOn;
  endsequence

  chk_pd_entry: assert property (
    seqPdEntry |=> s.mode == pmrc_pkg::MODE_PDOWN && !status.addrLatchStrobe
                   && !status.progFetchStrobe)
    else $error("power-down entry or strobes wrong");
  chk_idle_entry: assert property (
    seqIdleEntry |=> s.mode == pmrc_pkg::MODE_IDLE && status.idleBit)
    else $error("idle not entered after instruction");
  chk_idle_strobes: assert property (
    s.mode == pmrc_pkg::MODE_IDLE |-> status.addrLatchStrobe && status.progFetchStrobe
                                      && status.portFreeze)
    else $error("idle strobes or port freeze wrong");
  chk_core_gated: assert property (
    s.mode != pmrc_pkg::MODE_RUN |=> !status.coreCycleEn)
    else $error("core enable outside run");
  chk_idle_wake: assert property (
    s.mode == pmrc_pkg::MODE_IDLE && irqWake && !resetNow
      |=> s.mode == pmrc_pkg::MODE_RUN && !s.idleBit)
    else $error("interrupt did not end idle");
  chk_div_legal: assert property (
    s.div != `PMRC_DIV_RSVD)
    else $error("reserved divider in use");
  chk_switch_back: assert property (
    swTrig && oscOn |=> s.div == `PMRC_DIV_4 && !s.divPend)
    else $error("switchback did not force divide-by-4");
  chk_div_delay: assert property (
    divAccept && !swTrig && !resetNow |=> s.div == $past(s.div) && s.divPend)
    else $error("divider changed without delay");
  chk_busy_ignore: assert property (
    ctrl.divWr && ctrl.swbEn && ev.serialBusy && !s.divPend && !resetNow |=> !s.divPend)
    else $error("divide write taken during serial activity");
  chk_xtal_refuse: assert property (
    ctrl.clkSrcWr && ctrl.clkSrcSel && !xtalReady && !s.srcPend && !s.autoBack
      |=> !s.srcPend)
    else $error("crystal selected while not ready");
  chk_wd_reset: assert property (
    seqWdExpire |=> status.wdReset ##1 s.mode == pmrc_pkg::MODE_RESET)
    else $error("watchdog reset not issued");
  chk_rst_sample: assert property (
    coreFourth && oscOn |=> s.rstSampled == $past(s.rstPinSync[1]))
    else $error("reset pin not sampled at fourth state");
  chk_pd_reset: assert property (
    s.mode == pmrc_pkg::MODE_PDOWN && s.rstPinSync[1] |=> s.rstSampled
      ##1 s.mode == pmrc_pkg::MODE_RESET)
    else $error("reset pin did not end power-down");
  chk_reset_hold: assert property (
    s.mode == pmrc_pkg::MODE_RESET && $fell(s.rstSampled) && !s.pfSync[1]
      && !status.wdReset |-> status.cpuReset [*4])
    else $error("reset released too early");
  chk_pd_wake: assert property (
    s.mode == pmrc_pkg::MODE_PDOWN && pdWake && !resetNow
      |=> s.mode == pmrc_pkg::MODE_RUN && !s.pdBit)
    else $error("level interrupt did not wake power-down");
  chk_reset_div: assert property (
    resetNow |=> s.div == `PMRC_DIV_4 && status.cpuReset)
    else $error("reset did not force divide-by-4");
endmodule : pmrc_power_ctrl
`default_nettype wire

// [tb/pmrc_cpu_model.sv]
// Far-side model: reset pin and level-mode interrupt pin driven on bench request
`timescale 1ns/100ps
`default_nettype none
module pmrc_cpu_model #(
  parameter int HOLD_CLOCKS = 8
) (
  input  wire logic  clk,
  input  wire logic  wantReset,
  input  wire logic  wantIrq,
  output logic       rstPin,
  output logic [1:0] extIrqPin,
  output logic       irqWake
);
  logic [7:0] holdCnt = 8'h00;
  // Pin lingers two /4 machine cycles past the request, the shortest legal pulse
  always_ff @(posedge clk) begin
    if (wantReset) begin
      holdCnt <= 8'(HOLD_CLOCKS);
    end else if (holdCnt != 8'h00) begin
      holdCnt <= holdCnt - 8'h01;
    end
  end
  assign rstPin = wantReset | (holdCnt != 8'h00);
  // Level source holds its pin low until served; the unused pin idles high
  assign extIrqPin = {1'b1, ~wantIrq};
  assign irqWake = wantIrq;
endmodule : pmrc_cpu_model
`default_nettype wire

// [tb/pmrc_power_ctrl_bench.sv]
// Self-checking testbench of the power mode and reset control block
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.svh"
module pmrc_power_ctrl_bench;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  pmrc_pkg::pmrc_ctrl_s   ctrl = '0;
  pmrc_pkg::pmrc_event_s  ev = '0;
  logic                   instrDone = 1'b0;
  logic                   warm = 1'b1;
  logic                   wdTimeout = 1'b0;
  logic                   wdEn = 1'b0;
  logic                   wantReset = 1'b0;
  logic                   wantIrq = 1'b0;
  logic                   rxLine = 1'b1;
  logic                   pfLine = 1'b0;
  logic                   wdKick = 1'b0;
  logic                   strobeIn = 1'b1;
  logic                   irqWake;
  logic                   rstPin;
  logic [1:0]             extIrqPin;
  pmrc_pkg::pmrc_status_s st;
  int                     errTotal = 0;
  int                     checkCount = 0;

  always #2.5 clk = ~clk;

  pmrc_power_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .ev(ev),
    .instrDone(instrDone), .irqWake(irqWake), .serRxPin(rxLine), .extIrqPin(extIrqPin),
    .rstPin(rstPin), .powerFailPin(pfLine), .crystalWarmPin(warm), .wdTimeout(wdTimeout),
    .wdResetEnable(wdEn), .wdRestart(wdKick), .aleIn(strobeIn), .fetchIn(strobeIn),
    .status(st));

  pmrc_cpu_model u_cpu (.clk(clk), .wantReset(wantReset), .wantIrq(wantIrq),
    .rstPin(rstPin), .extIrqPin(extIrqPin), .irqWake(irqWake));

  task automatic report_and_stop;
    if (errTotal == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  // Clocks up to and including the next core cycle pulse
  task automatic next_core(output int n);
    n = 0;
    do begin
      step(1);
      n++;
      if (n > 3000) begin
        chk(11'h000, 11'h001);
        report_and_stop();
      end
    end while (st.coreCycleEn !== 1'b1);
  endtask : next_core

  task automatic wait_div(input logic [1:0] code);
    int n;
    for (n = 0; st.divCode !== code; n++) begin
      if (n > 2500) begin
        chk(11'h000, 11'h001);
        report_and_stop();
      end
      step(1);
    end
  endtask : wait_div

  task automatic wait_run;
    int n;
    for (n = 0; st.cpuReset !== 1'b0; n++) begin
      if (n > 300) begin
        chk(11'h000, 11'h001);
        report_and_stop();
      end
      step(1);
    end
  endtask : wait_run

  task automatic div_write(input logic [1:0] code);
    ctrl.divSel = code;
    ctrl.divWr = 1'b1;
    step(1);
    ctrl.divWr = 1'b0;
    step(1);
  endtask : div_write

  task automatic src_write(input logic sel);
    ctrl.clkSrcSel = sel;
    ctrl.clkSrcWr = 1'b1;
    step(1);
    ctrl.clkSrcWr = 1'b0;
  endtask : src_write

  task automatic enter_mode(input logic pd);
    ctrl.idleWr = ~pd;
    ctrl.pdWr = pd;
    instrDone = 1'b1;
    step(1);
    ctrl.idleWr = 1'b0;
    ctrl.pdWr = 1'b0;
    instrDone = 1'b0;
    step(2);
  endtask : enter_mode

  task automatic period_is(input logic [10:0] exp);
    int n;
    next_core(n);
    next_core(n);
    chk(11'(n), exp);
  endtask : period_is

  task automatic t_div;
    div_write(`PMRC_DIV_64);
    step(2);
    chk(11'(st.divCode), 11'h001);
    wait_div(`PMRC_DIV_64);
    period_is(11'h040);
    div_write(`PMRC_DIV_RSVD);
    step(300);
    chk(11'(st.divCode), 11'h002);
    div_write(`PMRC_DIV_4);
    wait_div(`PMRC_DIV_4);
    div_write(`PMRC_DIV_1024);
    wait_div(`PMRC_DIV_1024);
    period_is(11'h400);
  endtask : t_div

  // All three trigger kinds pull a slowed core back; a busy port blocks divider writes
  task automatic t_swb;
    ctrl.swbEn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      div_write(`PMRC_DIV_4);
      wait_div(`PMRC_DIV_4);
      div_write(`PMRC_DIV_64);
      wait_div(`PMRC_DIV_64);
      ev.txBufWrite = (i == 0);
      ev.extIrqAck = (i == 1);
      ev.rxEnable = (i == 2);
      rxLine = (i != 2);
      step(1);
      ev.txBufWrite = 1'b0;
      ev.extIrqAck = 1'b0;
      step(4);
      ev.rxEnable = 1'b0;
      rxLine = 1'b1;
      chk(11'(st.divCode), 11'h001);
    end
    ev.serialBusy = 1'b1;
    div_write(`PMRC_DIV_64);
    step(300);
    chk(11'(st.divCode), 11'h001);
    ev.serialBusy = 1'b0;
    ctrl.swbEn = 1'b0;
  endtask : t_swb

  task automatic t_src;
    src_write(`PMRC_SRC_RC);
    step(40);
    chk(11'(st.clkSrcStatus), 11'h000);
    ctrl.crystalAmpOff = 1'b1;
    step(4);
    src_write(`PMRC_SRC_CRYSTAL);
    step(40);
    chk(11'({st.crystalReady, st.clkSrcStatus}), 11'h000);
    ctrl.crystalAmpOff = 1'b0;
    step(4);
    src_write(`PMRC_SRC_CRYSTAL);
    step(40);
    chk(11'({st.crystalReady, st.clkSrcStatus}), 11'h003);
  endtask : t_src

  task automatic t_idle;
    int core;
    int per;
    core = 0;
    per = 0;
    // Run strobes held low so the idle override is visible
    strobeIn = 1'b0;
    enter_mode(1'b0);
    chk(11'({st.idleBit, st.addrLatchStrobe, st.progFetchStrobe, st.portFreeze}),
        11'h00f);
    repeat (40) begin
      step(1);
      core += int'(st.coreCycleEn === 1'b1);
      per += int'(st.periphCycleEn === 1'b1);
    end
    chk(11'(core), 11'h000);
    chk(11'(per), 11'h00a);
    wantIrq = 1'b1;
    step(3);
    wantIrq = 1'b0;
    chk(11'({st.idleBit, st.portFreeze, st.addrLatchStrobe, st.progFetchStrobe}),
        11'h000);
    enter_mode(1'b0);
    wantReset = 1'b1;
    step(20);
    chk(11'({st.cpuReset, st.idleBit}), 11'h002);
    wantReset = 1'b0;
    wait_run();
    strobeIn = 1'b1;
  endtask : t_idle

  task automatic t_pd;
    ctrl.extLevelMode = 2'h1;
    ctrl.extIrqEnable = 2'h1;
    ctrl.globalIrqEnable = 1'b1;
    enter_mode(1'b1);
    chk(11'({st.pdBit, st.addrLatchStrobe, st.progFetchStrobe, st.oscRun, st.crystalAmpOn,
        st.rcOscOn}), 11'h020);
    wantIrq = 1'b1;
    step(6);
    wantIrq = 1'b0;
    chk(11'({st.pdBit, st.oscRun}), 11'h001);
    ctrl.rcWakeSelect = 1'b1;
    warm = 1'b0;
    // Let the released pin and the cold crystal pass the synchronisers first
    step(4);
    enter_mode(1'b1);
    chk(11'(st.oscRun), 11'h000);
    wantIrq = 1'b1;
    step(6);
    wantIrq = 1'b0;
    chk(11'({st.pdBit, st.clkSrcStatus, st.rcOscOn, st.crystalAmpOn}), 11'h003);
    warm = 1'b1;
    step(6);
    chk(11'({st.clkSrcStatus, st.rcOscOn}), 11'h002);
    enter_mode(1'b1);
    wantReset = 1'b1;
    step(10);
    chk(11'({st.cpuReset, st.pdBit}), 11'h002);
    wantReset = 1'b0;
    wait_run();
  endtask : t_pd

  task automatic t_wd;
    int n;
    div_write(`PMRC_DIV_64);
    wait_div(`PMRC_DIV_64);
    wdEn = 1'b1;
    wdTimeout = 1'b1;
    step(1);
    wdTimeout = 1'b0;
    step(100);
    wdKick = 1'b1;
    step(1);
    wdKick = 1'b0;
    n = 0;
    repeat (600) begin
      step(1);
      n += int'(st.wdReset === 1'b1);
    end
    chk(11'(n), 11'h000);
    wdTimeout = 1'b1;
    step(1);
    wdTimeout = 1'b0;
    n = 0;
    do begin
      step(1);
      n++;
    end while (st.wdReset !== 1'b1 && n < 600);
    chk(11'(n), 11'h200);
    step(2);
    chk(11'({st.cpuReset, st.divCode}), 11'h005);
    wdEn = 1'b0;
    wait_run();
    div_write(`PMRC_DIV_64);
    wait_div(`PMRC_DIV_64);
    pfLine = 1'b1;
    step(6);
    chk(11'({st.cpuReset, st.divCode}), 11'h005);
    pfLine = 1'b0;
    wait_run();
  endtask : t_wd

  initial begin
    step(8);
    rst_n = 1'b1;
    wait_run();
    chk(11'({st.divCode, st.clkSrcStatus, st.idleBit, st.pdBit}), 11'h00c);
    period_is(11'h004);
    t_div();
    t_swb();
    t_src();
    t_idle();
    t_pd();
    t_wd();
    report_and_stop();
  end
endmodule : pmrc_power_ctrl_bench
`default_nettype wire
